// >>> design/fsc_status_regs.sv
// Status and configuration register bank of a serial NOR flash
`timescale 1ns/1ps
`include "fsc_cfg.svh"

// Operation
// - Busy bit zero stays set while program, erase or register write runs.
// - While busy, only status reads and suspend are obeyed.
// - Busy clears when the running operation completes.
// - Write enable sets the write enable latch.
// - Latch clears at power-up, write disable, program, erase, status write.
// - Block protect field is writable and resets to zero.
// - Top or bottom select picks protected end, default top.
// - Small granule select picks sectors or blocks, default blocks.
// - Complement bit inverts the protected region chosen by the protection fields.
// - Complement bit resets to zero.
// - Protection writes need the latch and write protection state.
// - Both protect bits clear: pin ignored, latch alone allows writes.
// - Write protect set, lockdown clear, pin low: writes refused.
// - Write protect set, pin high: writes allowed with the latch.
// - Lockdown refuses writes until power cycle, which clears it.
// - Prefix AAh then 55h before a lockdown write sets a second lock; power cycle clears both.
// - Protect pin counts only for standard and dual transfers.
// - Suspend sets paused flag; resume or power cycle clears it.
// - Security lock bits default zero and once set stay set.
// - Quad enable gates quad transfers and pin reuse.
// - Scheme select picks per-block locks or protection fields.
// - Reserved bits ignore writes and read as zero.
module fsc_status_regs #(
  parameter logic [`FSC_CNT_W-1:0] TW_CYCLES  = `FSC_TW_RST,
  parameter logic                  QE_DEFAULT = 1'h0
) (
  input  wire logic               core_clk_in,
  input  wire logic               reset_in,
  input  wire logic               link_clk_in,
  input  wire logic               cmd_valid_in,
  input  wire fsc_pkg::fsc_cmd_s  cmd_in,
  input  wire logic               write_protect_pin_n_in,
  input  wire logic               array_done_in,
  output fsc_pkg::fsc_stat_s      status_out,
  output logic                    cmd_busy_out,
  output fsc_pkg::fsc_stat_s      cfg_out,
  output logic                    array_start_out,
  output fsc_pkg::fsc_kind_e      array_op_out,
  output logic                    prot_invert_out,
  output logic                    block_locks_out
);

  fsc_pkg::fsc_core_s c;
  fsc_pkg::fsc_core_s next_c;
  fsc_pkg::fsc_link_s l;
  fsc_pkg::fsc_link_s next_l;
  fsc_pkg::fsc_cmd_s  cmd;
  logic               got;
  logic               quad_ok;
  logic               is_sus;
  logic               is_res;
  logic               wp_high;
  logic               wr_ok;

  // Overlay one written byte, keep status-only bits
  function automatic fsc_pkg::fsc_stat_s wr_merge(
    input fsc_pkg::fsc_stat_s      old,
    input logic [1:0]              sel,
    input logic [`FSC_BYTE_W-1:0]  data
  );
    logic [$bits(fsc_pkg::fsc_stat_s)-1:0] w;
    fsc_pkg::fsc_stat_s                    m;
    w = old;
    w[sel*`FSC_BYTE_W +: `FSC_BYTE_W] = data;
    m = w;
    m.busy = old.busy;
    m.write_enable_latch = old.write_enable_latch;
    m.paused_flag = old.paused_flag;
    m.otp_lock = old.otp_lock | m.otp_lock;
    m.rsv_23 = 1'b0;
    m.rsv_20_19 = 2'h0;
    m.rsv_17_16 = 2'h0;
    m.rsv_10 = 1'b0;
    return m;
  endfunction

  // Decoded view of the held instruction
  assign cmd     = l.hold;
  assign got     = c.req_sync != c.ack;
  assign is_sus  = cmd.opcode == `FSC_OP_SUSPEND;
  assign is_res  = cmd.opcode == `FSC_OP_RESUME;
  // quad transfer only with quad enable
  assign quad_ok = !cmd.quad || c.st.quad_enable;
  // pin is a data line in quad transfers
  assign wp_high = c.wp_sync || cmd.quad;
  // write gate from latch and protection
  assign wr_ok   = c.st.write_enable_latch
                 && !c.st.status_lockdown
                 && !c.perm
                 && (!c.st.status_write_protect || wp_high);

  // Core next state: syncs, timer, instruction execution
  always_comb begin
    next_c = c;
    next_c.wp_meta = write_protect_pin_n_in;
    next_c.wp_sync = c.wp_meta;
    next_c.req_meta = l.req;
    next_c.req_sync = c.req_meta;
    next_c.sack_meta = l.sn_seen;
    next_c.sack_sync = c.sack_meta;
    next_c.start = 1'b0;
    // status write ends after the timer
    if (c.src == fsc_pkg::FSC_SRC_STATUS) begin
      if (c.cnt == '0) begin
        next_c.st.busy = 1'b0;
        next_c.src = fsc_pkg::FSC_SRC_IDLE;
      end else begin
        next_c.cnt = c.cnt - 1'b1;
      end
    end
    if (c.src == fsc_pkg::FSC_SRC_ARRAY && array_done_in) begin
      next_c.st.busy = 1'b0;
      next_c.src = fsc_pkg::FSC_SRC_IDLE;
    end
    if (got) begin
      next_c.ack = c.req_sync;
      next_c.pre = fsc_pkg::FSC_PRE_NONE;
      if (!quad_ok) begin
        next_c.ack = c.req_sync;
      end else if (is_sus) begin
        // suspend only a running array job
        if (c.src == fsc_pkg::FSC_SRC_ARRAY && !array_done_in) begin
          next_c.st.paused_flag = 1'b1;
          next_c.st.busy = 1'b0;
          next_c.src = fsc_pkg::FSC_SRC_PAUSED;
        end
      end else if (is_res) begin
        if (c.src == fsc_pkg::FSC_SRC_PAUSED) begin
          next_c.st.paused_flag = 1'b0;
          next_c.st.busy = 1'b1;
          next_c.src = fsc_pkg::FSC_SRC_ARRAY;
        end
      end else if (!c.st.busy) begin
        if (cmd.opcode == `FSC_OP_PREFIX_A) begin
          next_c.pre = fsc_pkg::FSC_PRE_FIRST;
        end else if (cmd.opcode == `FSC_OP_PREFIX_B &&
                     c.pre == fsc_pkg::FSC_PRE_FIRST) begin
          next_c.pre = fsc_pkg::FSC_PRE_ARMED;
        end
        case (cmd.kind)
          fsc_pkg::FSC_K_WR_ENABLE: begin
            next_c.st.write_enable_latch = 1'b1;
          end
          fsc_pkg::FSC_K_WR_DISABLE: begin
            next_c.st.write_enable_latch = 1'b0;
          end
          fsc_pkg::FSC_K_WRITE_STATUS: begin
            if (wr_ok && cmd.reg_sel != 2'h3) begin
              next_c.st = wr_merge(c.st, cmd.reg_sel, cmd.data);
              next_c.st.write_enable_latch = 1'b0;
              next_c.st.busy = 1'b1;
              next_c.src = fsc_pkg::FSC_SRC_STATUS;
              next_c.cnt = TW_CYCLES;
              if (c.pre == fsc_pkg::FSC_PRE_ARMED &&
                  next_c.st.status_lockdown) begin
                next_c.perm = 1'b1;
              end
            end
          end
          fsc_pkg::FSC_K_PROGRAM,
          fsc_pkg::FSC_K_ERASE,
          fsc_pkg::FSC_K_SEC_ERASE,
          fsc_pkg::FSC_K_SEC_PROGRAM: begin
            // No new job while another is paused
            if (c.st.write_enable_latch &&
                c.src == fsc_pkg::FSC_SRC_IDLE) begin
              // latch cleared by program or erase
              next_c.st.write_enable_latch = 1'b0;
              // busy until the array is done
              next_c.st.busy = 1'b1;
              next_c.src = fsc_pkg::FSC_SRC_ARRAY;
              next_c.start = 1'b1;
              next_c.op = cmd.kind;
            end
          end
          default: begin
            next_c.op = c.op;
          end
        endcase
      end
    end
    // inversion applies only to the field scheme
    next_c.inv = next_c.st.complement_protect &&
                 !next_c.st.protect_scheme_select;
    next_c.locks = next_c.st.protect_scheme_select;
    // Refresh the read copy once the link took the last one
    if (c.sack_sync == c.snap_tgl) begin
      next_c.snap = c.st;
      next_c.snap_tgl = !c.snap_tgl;
    end
  end

  // Core registers; reset is the power cycle
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      c <= '0;
      c.st.drive_strength_high <= `FSC_DRV_RST;
      c.st.drive_strength_low <= `FSC_DRV_RST;
      c.st.quad_enable <= QE_DEFAULT;
    end else begin
      c <= next_c;
    end
  end

  // Link next state: command capture and read copy
  always_comb begin
    next_l = l;
    next_l.rst_meta = reset_in;
    next_l.rst_sync = l.rst_meta;
    next_l.ack_meta = c.ack;
    next_l.ack_sync = l.ack_meta;
    next_l.sn_meta = c.snap_tgl;
    next_l.sn_sync = l.sn_meta;
    // Copy is stable while its toggle is unanswered
    if (l.sn_sync != l.sn_seen) begin
      next_l.rd = c.snap;
      next_l.sn_seen = l.sn_sync;
    end
    // One command in flight; a second is dropped
    if (cmd_valid_in && l.req == l.ack_sync) begin
      next_l.hold = cmd_in;
      next_l.req = !l.req;
    end
    next_l.pend = next_l.req != next_l.ack_sync;
    if (l.rst_sync) begin
      next_l.req = 1'b0;
      next_l.pend = 1'b0;
      next_l.sn_seen = 1'b0;
      next_l.hold = '0;
      next_l.rd = '0;
    end
  end

  // Link registers; reset arrives through two stages
  always_ff @(posedge link_clk_in) begin
    l <= next_l;
  end

  // Outputs straight from state
  assign status_out      = l.rd;
  assign cmd_busy_out    = l.pend;
  assign cfg_out         = c.st;
  assign array_start_out = c.start;
  assign array_op_out    = c.op;
  assign prot_invert_out = c.inv;
  assign block_locks_out = c.locks;

  // Checks in the core domain
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (reset_in);

  logic wrsr;
  logic run;
  assign wrsr = got && quad_ok && !c.st.busy && !is_sus && !is_res
              && cmd.kind == fsc_pkg::FSC_K_WRITE_STATUS;
  assign run  = got && quad_ok && !c.st.busy && !is_sus && !is_res;

  a_start_busy: assert property (
    c.start |-> c.st.busy && !c.st.write_enable_latch
             && c.src == fsc_pkg::FSC_SRC_ARRAY)
    else $error("array start without busy");

  a_busy_ignores: assert property (
    c.st.busy && got && !is_sus && !is_res
    |=> $stable(c.st.write_enable_latch)
        && $stable(c.st.block_protect))
    else $error("instruction acted while busy");

  a_done_clears: assert property (
    c.src == fsc_pkg::FSC_SRC_ARRAY && array_done_in
    |=> !c.st.busy ##1 !c.start)
    else $error("busy stuck after array done");

  a_tw_ends: assert property (
    c.src == fsc_pkg::FSC_SRC_STATUS && c.cnt == '0
    |=> !c.st.busy && c.src == fsc_pkg::FSC_SRC_IDLE)
    else $error("status write time overrun");

  a_wel_set: assert property (
    run && cmd.kind == fsc_pkg::FSC_K_WR_ENABLE
    |=> c.st.write_enable_latch)
    else $error("write enable lost");

  a_wr_refused: assert property (
    wrsr && !wr_ok |=> $stable(c.st))
    else $error("refused status write changed state");

  a_wp_low: assert property (
    wrsr && !cmd.quad && c.st.status_write_protect && !c.wp_sync
    |=> $stable(c.st.block_protect) && $stable(c.st.quad_enable))
    else $error("write taken with protect pin low");

  a_unprot_ok: assert property (
    wrsr && wr_ok && cmd.reg_sel == `FSC_REG_ONE
    |=> c.st.block_protect == $past(cmd.data[4:2])
        && c.st.busy && !c.st.write_enable_latch)
    else $error("accepted write not applied");

  a_lock_holds: assert property (
    c.st.status_lockdown |=> c.st.status_lockdown)
    else $error("lockdown dropped without power cycle");

  a_otp_sticky: assert property (
    (c.st.otp_lock & $past(c.st.otp_lock)) == $past(c.st.otp_lock))
    else $error("security lock bit cleared");

  a_suspend_sets: assert property (
    got && quad_ok && is_sus && !array_done_in
    && c.src == fsc_pkg::FSC_SRC_ARRAY
    |=> c.st.paused_flag && !c.st.busy)
    else $error("suspend not taken");

  a_quad_blocked: assert property (
    got && cmd.quad && !c.st.quad_enable
    |=> $stable(c.st.write_enable_latch) && !c.start)
    else $error("quad instruction ran without quad enable");

  // Refused under the permanent lock: no busy time, fields untouched
  a_perm_final: assert property (
    c.perm && wrsr |=> c.perm && !c.st.busy && $stable(c.st.block_protect))
    else $error("permanent lock bypassed");

  a_wel_clear: assert property (
    run && cmd.kind == fsc_pkg::FSC_K_WR_DISABLE
    |=> !c.st.write_enable_latch)
    else $error("write disable kept the latch");

  a_resume_busy: assert property (
    got && quad_ok && is_res && c.src == fsc_pkg::FSC_SRC_PAUSED
    |=> !c.st.paused_flag && c.st.busy)
    else $error("resume did not restart the job");

  a_rsv_zero: assert property (
    c.st.rsv_23 == 1'b0 && c.st.rsv_20_19 == 2'h0
    && c.st.rsv_17_16 == 2'h0 && c.st.rsv_10 == 1'b0)
    else $error("reserved status bit set");

  a_sec_write: assert property (
    wrsr && wr_ok && cmd.reg_sel == `FSC_REG_ONE
    |=> c.st.small_granule_select == $past(cmd.data[6])
        && c.st.top_or_bottom_select == $past(cmd.data[5]))
    else $error("granule or end select not applied");

  c_status_write: cover property (
    wrsr && wr_ok ##1 c.st.busy);
  c_array_job: cover property (
    c.start ##[1:200] array_done_in);
  c_pause_resume: cover property (
    c.st.paused_flag ##[1:200] !c.st.paused_flag);
  c_perm_lock: cover property (
    $rose(c.perm));

endmodule

// >>> inc/fsc_cfg.svh
// Bit widths, reset values, timer default and opcodes of the status bank
`ifndef FSC_CFG_SVH
`define FSC_CFG_SVH
`define FSC_BYTE_W 8
`define FSC_CNT_W 16
`define FSC_DRV_RST 1'h1
`define FSC_TW_RST 16'h0010
`define FSC_OP_SUSPEND 8'h75
`define FSC_OP_RESUME 8'h7a
`define FSC_OP_PREFIX_A 8'haa
`define FSC_OP_PREFIX_B 8'h55
`define FSC_REG_ONE 2'h0
`define FSC_REG_TWO 2'h1
`define FSC_REG_THREE 2'h2
`endif

// >>> inc/fsc_pkg.sv
// Types of the flash status and configuration bank
`include "fsc_cfg.svh"
package fsc_pkg;

  // Three status bytes, most significant field first
  typedef struct packed {
    logic                 rsv_23;
    logic                 drive_strength_high;
    logic                 drive_strength_low;
    logic [1:0]           rsv_20_19;
    logic                 protect_scheme_select;
    logic [1:0]           rsv_17_16;
    logic                 paused_flag;
    logic                 complement_protect;
    logic [2:0]           otp_lock;
    logic                 rsv_10;
    logic                 quad_enable;
    logic                 status_lockdown;
    logic                 status_write_protect;
    logic                 small_granule_select;
    logic                 top_or_bottom_select;
    logic [2:0]           block_protect;
    logic                 write_enable_latch;
    logic                 busy;
  } fsc_stat_s;

  // Decoded instruction classes
  typedef enum logic [3:0] {
    FSC_K_OTHER,
    FSC_K_WR_ENABLE,
    FSC_K_WR_DISABLE,
    FSC_K_WRITE_STATUS,
    FSC_K_PROGRAM,
    FSC_K_ERASE,
    FSC_K_SEC_ERASE,
    FSC_K_SEC_PROGRAM
  } fsc_kind_e;

  // What keeps the busy bit up
  typedef enum logic [1:0] {
    FSC_SRC_IDLE,
    FSC_SRC_STATUS,
    FSC_SRC_ARRAY,
    FSC_SRC_PAUSED
  } fsc_src_e;

  // Permanent lock prefix tracking
  typedef enum logic [1:0] {
    FSC_PRE_NONE,
    FSC_PRE_FIRST,
    FSC_PRE_ARMED
  } fsc_pre_e;

  // One instruction from the decoder
  typedef struct packed {
    fsc_kind_e            kind;
    logic [`FSC_BYTE_W-1:0] opcode;
    logic                 quad;
    logic [1:0]           reg_sel;
    logic [`FSC_BYTE_W-1:0] data;
  } fsc_cmd_s;

  // Core domain state
  typedef struct packed {
    logic                 wp_meta;
    logic                 wp_sync;
    logic                 req_meta;
    logic                 req_sync;
    logic                 ack;
    logic                 snap_tgl;
    logic                 sack_meta;
    logic                 sack_sync;
    logic                 start;
    logic                 inv;
    logic                 locks;
    logic                 perm;
    fsc_src_e             src;
    fsc_pre_e             pre;
    fsc_kind_e            op;
    logic [`FSC_CNT_W-1:0] cnt;
    fsc_stat_s            st;
    fsc_stat_s            snap;
  } fsc_core_s;

  // Link domain state
  typedef struct packed {
    logic                 rst_meta;
    logic                 rst_sync;
    logic                 req;
    logic                 ack_meta;
    logic                 ack_sync;
    logic                 pend;
    logic                 sn_meta;
    logic                 sn_sync;
    logic                 sn_seen;
    fsc_cmd_s             hold;
    fsc_stat_s            rd;
  } fsc_link_s;

endpackage

// >>> sim/fsc_host_model.sv
// Host side model sending decoded instructions on the link clock
`timescale 1ns/1ps
module fsc_host_model (
  input  wire logic         link_clk_in,
  input  wire logic         cmd_busy_in,
  output logic              cmd_valid_out,
  output fsc_pkg::fsc_cmd_s cmd_out,
  output logic              timeout_out
);
  initial begin
    cmd_valid_out = 1'b0;
    cmd_out = '0;
    timeout_out = 1'b0;
  end

  // Bounded wait for the busy level; a hang flags a timeout
  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (cmd_busy_in !== lvl && n < lim) begin
      @(negedge link_clk_in);
      n++;
    end
    if (cmd_busy_in !== lvl) begin
      timeout_out = 1'b1;
    end
  endtask

  // One whole instruction; idle lines then carry the inverse, not stale data
  task automatic send(input fsc_pkg::fsc_cmd_s cmd, input int slow);
    wait_busy(1'b0, 64);
    repeat (slow) @(negedge link_clk_in);
    cmd_valid_out = 1'b1;
    cmd_out = cmd;
    @(negedge link_clk_in);
    cmd_valid_out = 1'b0;
    cmd_out = ~cmd;
    wait_busy(1'b1, 8);
    wait_busy(1'b0, 64);
  endtask
endmodule

// >>> sim/tb.sv
// Self-checking bench of the flash status register bank
`timescale 1ns/1ps
module tb;
  localparam logic [15:0] TW = 16'h0002;
  logic               core_clk_in;
  logic               link_clk_in;
  logic               reset_in;
  logic               wp_n;
  logic               done;
  logic               cmd_valid;
  logic               timeout;
  logic               cmd_busy;
  logic               start;
  logic               inv;
  logic               locks;
  fsc_pkg::fsc_cmd_s  cmd;
  fsc_pkg::fsc_stat_s status;
  fsc_pkg::fsc_stat_s cfg;
  fsc_pkg::fsc_stat_s exp;
  fsc_pkg::fsc_kind_e op;
  fsc_pkg::fsc_stat_s notes[$];
  int                 miscompares;
  int                 checked;
  int                 busy_cycles;
  int                 starts;
  event               chk_ev;

  fsc_status_regs #(.TW_CYCLES(TW), .QE_DEFAULT(1'h0)) uut (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .link_clk_in(link_clk_in),
    .cmd_valid_in(cmd_valid), .cmd_in(cmd), .write_protect_pin_n_in(wp_n),
    .array_done_in(done), .status_out(status), .cmd_busy_out(cmd_busy), .cfg_out(cfg),
    .array_start_out(start), .array_op_out(op), .prot_invert_out(inv),
    .block_locks_out(locks));

  fsc_host_model host (.link_clk_in(link_clk_in), .cmd_busy_in(cmd_busy),
    .cmd_valid_out(cmd_valid), .cmd_out(cmd), .timeout_out(timeout));

  // Clocks with unrelated phase
  always #5 core_clk_in = ~core_clk_in;
  always #32 link_clk_in = ~link_clk_in;

  // Busy and start pulses counted per core cycle, away from the launch edge
  always @(negedge core_clk_in) begin
    if (cfg.busy === 1'b1) busy_cycles++;
    if (start === 1'b1) starts++;
  end

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] want);
    checked++;
    if (seen !== want) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic give_verdict();
    $display("counts: %0d checked, %0d miscompares", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Oldest note compared against both register copies
  always @(chk_ev) begin
    fsc_pkg::fsc_stat_s w;
    w = notes.pop_front();
    check("cfg_out", cfg, w);
    check("status_out", status, w);
  end

  always @(posedge timeout) begin
    miscompares++;
    give_verdict();
  end

  task automatic note();
    notes.push_back(exp);
    ->chk_ev;
    #1;
  endtask

  // Reset long enough for both domains, link side needs three edges
  task automatic do_reset();
    @(negedge core_clk_in);
    reset_in = 1'b1;
    repeat (20) @(negedge core_clk_in);
    repeat (4) @(posedge link_clk_in);
    @(negedge core_clk_in);
    reset_in = 1'b0;
    exp = '0;
    exp.drive_strength_high = 1'b1;
    exp.drive_strength_low = 1'b1;
    repeat (14) @(negedge link_clk_in);
  endtask

  task automatic issue(input fsc_pkg::fsc_kind_e k, input logic [7:0] opc, input logic q,
                       input logic [1:0] sel, input logic [7:0] d);
    fsc_pkg::fsc_cmd_s c;
    c.kind = k;
    c.opcode = opc;
    c.quad = q;
    c.reg_sel = sel;
    c.data = d;
    host.send(c, $urandom_range(0, 3));
  endtask

  // Wait out the write time, then let the read copy catch up
  task automatic settle();
    int n;
    n = 0;
    while (cfg.busy !== 1'b0 && n < 200) begin
      @(negedge core_clk_in);
      n++;
    end
    if (cfg.busy !== 1'b0) begin
      miscompares++;
      give_verdict();
    end
    repeat (12) @(negedge link_clk_in);
  endtask

  // Writable bits per byte; lock bits only ever merge in
  function automatic fsc_pkg::fsc_stat_s apply(fsc_pkg::fsc_stat_s s, logic [1:0] sel,
                                               logic [7:0] d);
    logic [23:0] v;
    v = s;
    case (sel)
      2'h0: v[7:2] = d[7:2];
      2'h1: begin
        v[9:8] = d[1:0];
        v[14] = d[6];
        v[13:11] = v[13:11] | d[5:3];
      end
      2'h2: begin
        v[18] = d[2];
        v[22:21] = d[6:5];
      end
      default: ;
    endcase
    v[1] = 1'b0;
    return v;
  endfunction

  task automatic wr(input logic [1:0] sel, input logic [7:0] d, input logic q, input logic ok);
    issue(fsc_pkg::FSC_K_WR_ENABLE, 8'h00, 1'b0, 2'h0, 8'h00);
    exp.write_enable_latch = 1'b1;
    busy_cycles = 0;
    issue(fsc_pkg::FSC_K_WRITE_STATUS, 8'h00, q, sel, d);
    settle();
    if (ok) exp = apply(exp, sel, d);
    check("busy_cycles", 24'(busy_cycles), ok ? 24'(TW + 16'h0001) : 24'h00_0000);
    note();
  endtask

  initial begin
    core_clk_in = 1'b0;
    link_clk_in = 1'b0;
    wp_n = 1'b1;
    done = 1'b0;
    miscompares = 0;
    checked = 0;
    reset_in = 1'b1;
    void'($urandom(1270));
    do_reset();
    note();
    busy_cycles = 0;
    issue(fsc_pkg::FSC_K_WRITE_STATUS, 8'h00, 1'b0, 2'h0, 8'hfc);
    settle();
    check("busy_cycles", 24'(busy_cycles), 24'h00_0000);
    note();
    $display("test defaults_and_refusal done");
    for (int i = 0; i < 3; i++) wr(2'h0, 8'($urandom_range(0, 127)), 1'b0, 1'b1);
    wr(2'h1, 8'hc4, 1'b0, 1'b1);
    check("prot_invert", inv, 1'b1);
    wr(2'h2, 8'h9b, 1'b0, 1'b1);
    wr(2'h2, 8'h04, 1'b0, 1'b1);
    check("block_locks", locks, 1'b1);
    check("prot_invert", inv, 1'b0);
    wr(2'h1, 8'h28, 1'b0, 1'b1);
    wr(2'h1, 8'h00, 1'b0, 1'b1);
    $display("test fields done");
    wr(2'h0, 8'h80, 1'b0, 1'b1);
    wr(2'h0, 8'h84, 1'b1, 1'b0);
    wp_n = 1'b0;
    wr(2'h0, 8'h9c, 1'b0, 1'b0);
    wp_n = 1'b1;
    wr(2'h1, 8'h02, 1'b0, 1'b1);
    wp_n = 1'b0;
    wr(2'h0, 8'h84, 1'b1, 1'b1);
    wp_n = 1'b1;
    $display("test pin_protect done");
    wr(2'h1, 8'h03, 1'b0, 1'b1);
    wr(2'h0, 8'h00, 1'b0, 1'b0);
    do_reset();
    note();
    wr(2'h0, 8'h1c, 1'b0, 1'b1);
    $display("test lockdown done");
    starts = 0;
    issue(fsc_pkg::FSC_K_WR_ENABLE, 8'h00, 1'b0, 2'h0, 8'h00);
    issue(fsc_pkg::FSC_K_PROGRAM, 8'h00, 1'b0, 2'h0, 8'h00);
    check("busy", cfg.busy, 1'b1);
    check("array_op", op, fsc_pkg::FSC_K_PROGRAM);
    check("starts", 24'(starts), 24'h00_0001);
    check("latch", cfg.write_enable_latch, 1'b0);
    issue(fsc_pkg::FSC_K_WR_ENABLE, 8'h00, 1'b0, 2'h0, 8'h00);
    check("latch", cfg.write_enable_latch, 1'b0);
    issue(fsc_pkg::FSC_K_OTHER, 8'h75, 1'b0, 2'h0, 8'h00);
    check("paused", cfg.paused_flag, 1'b1);
    check("busy", cfg.busy, 1'b0);
    issue(fsc_pkg::FSC_K_OTHER, 8'h7a, 1'b0, 2'h0, 8'h00);
    check("paused", cfg.paused_flag, 1'b0);
    check("busy", cfg.busy, 1'b1);
    @(negedge core_clk_in);
    done = 1'b1;
    @(negedge core_clk_in);
    done = 1'b0;
    settle();
    note();
    $display("test array_job done");
    issue(fsc_pkg::FSC_K_WR_ENABLE, 8'h00, 1'b0, 2'h0, 8'h00);
    issue(fsc_pkg::FSC_K_SEC_ERASE, 8'h00, 1'b0, 2'h0, 8'h00);
    check("busy", cfg.busy, 1'b1);
    check("array_op", op, fsc_pkg::FSC_K_SEC_ERASE);
    check("latch", cfg.write_enable_latch, 1'b0);
    @(negedge core_clk_in);
    done = 1'b1;
    @(negedge core_clk_in);
    done = 1'b0;
    settle();
    check("busy", cfg.busy, 1'b0);
    issue(fsc_pkg::FSC_K_WR_ENABLE, 8'h00, 1'b0, 2'h0, 8'h00);
    issue(fsc_pkg::FSC_K_WR_DISABLE, 8'h00, 1'b0, 2'h0, 8'h00);
    busy_cycles = 0;
    issue(fsc_pkg::FSC_K_WRITE_STATUS, 8'h00, 1'b0, 2'h0, 8'h1c);
    settle();
    check("busy_cycles", 24'(busy_cycles), 24'h00_0000);
    note();
    wr(2'h3, 8'hff, 1'b0, 1'b0);
    $display("test disable_and_erase done");
    // Prefix pair then a lockdown write arms the permanent lock
    issue(fsc_pkg::FSC_K_WR_ENABLE, 8'h00, 1'b0, 2'h0, 8'h00);
    issue(fsc_pkg::FSC_K_OTHER, 8'haa, 1'b0, 2'h0, 8'h00);
    issue(fsc_pkg::FSC_K_OTHER, 8'h55, 1'b0, 2'h0, 8'h00);
    busy_cycles = 0;
    issue(fsc_pkg::FSC_K_WRITE_STATUS, 8'h00, 1'b0, 2'h1, 8'h01);
    settle();
    exp = apply(exp, 2'h1, 8'h01);
    check("busy_cycles", 24'(busy_cycles), 24'(TW + 16'h0001));
    note();
    wr(2'h0, 8'h00, 1'b0, 1'b0);
    $display("test prefix_lock done");
    give_verdict();
  end
endmodule
